// ### core/slrs_pkg.sv
/*
 package of the serial link reset sequencer: timing counts, filter lengths
 and the state encoding of the reset sequencer.
 assumes a single 200 MHz clock (mclk) drives every module.
*/
package slrs_pkg;

   localparam int unsigned CLK_MHZ          = 200;
   // core reset and one-way system resets are held at least this long
   localparam int unsigned RST_MIN_CYC      = 6;
   // link-ready of the one-way cores drops no sooner than this
   localparam int unsigned READY_DROP_CYC   = 5;
   // staging delay of the initialization request
   localparam int unsigned INIT_DELAY_CYC   = 128;
   // width of the stretch counter
   localparam int unsigned STRETCH_BITS     = 24;
   // width of the one-way tx ready-delay timer
   localparam int unsigned TX_TIMER_BITS    = 24;
   // default ready-delay count of the one-way tx timer
   localparam int unsigned TX_TIMER_CYC     = 4096;
   // debounce filter length
   localparam int unsigned DEBOUNCE_CYC     = 16;
   // cycles after initialization that the link clock is taken to stop
   localparam int unsigned CLK_STOP_CYC     = 4;

   typedef enum logic [3:0] {
      SLRS_IDLE  = 4'b0001,
      SLRS_RESET = 4'b0010,
      SLRS_TRAIN = 4'b0100,
      SLRS_READY = 4'b1000
   } slrs_state_e;

endpackage

// ### core/slrs_if.sv
/*
 interface between the reset sequencer top and its debounce and staging
 helpers. assumes all three modules share mclk and nrst.
*/
`timescale 1ns/1ps
`default_nettype none
interface slrs_if;
   logic raw_rst;
   logic clean_rst;
   logic init_req;
   logic init_stage;
   logic init_stretch;
   logic init_agg;

   modport deb (input raw_rst, output clean_rst);
   modport stg (input init_req, output init_stage, output init_stretch,
                output init_agg);
   modport top (output raw_rst, input clean_rst, output init_req,
                input init_stage, input init_stretch, input init_agg);
endinterface
`default_nettype wire

// ### core/slrs_debounce.sv
/*
 debounce filter for the pushbutton reset: output follows the raw input
 only after it has been steady for DEBOUNCE_LEN cycles.
 assumes the raw input is synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module slrs_debounce
   import slrs_pkg::*;
#(
   parameter int unsigned DEBOUNCE_LEN = DEBOUNCE_CYC
) (
   input  wire logic mclk,
   input  wire logic nrst,
   slrs_if.deb       bus
);
   typedef struct packed {
      logic        last;
      logic        out;
      logic [15:0] cnt;
   } slrs_deb_s;

   slrs_deb_s st;
   slrs_deb_s next_st;

   always_comb begin
      next_st = st;
      next_st.last = bus.raw_rst;
      if (bus.raw_rst != st.last) begin
         next_st.cnt = 16'h0000;
      end else if (st.cnt < 16'(DEBOUNCE_LEN - 1)) begin
         next_st.cnt = st.cnt + 16'h0001;
      end else begin
         next_st.out = st.last;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st <= '{last: 1'b1, out: 1'b1, cnt: 16'h0000};
      end else begin
         st <= next_st;
      end
   end

   assign bus.clean_rst = st.out;
endmodule
`default_nettype wire

// ### core/slrs_stage.sv
/*
 staging of the transceiver initialization request: a delayed copy, a
 stretched pulse, and their union.
 assumes the request is synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module slrs_stage
   import slrs_pkg::*;
#(
   parameter int unsigned DELAY_LEN = INIT_DELAY_CYC,
   parameter int unsigned STR_BITS  = STRETCH_BITS
) (
   input  wire logic mclk,
   input  wire logic nrst,
   slrs_if.stg       bus
);
   typedef struct packed {
      logic [DELAY_LEN-1:0] dly;
      logic [STR_BITS-1:0]  str;
      logic                 agg;
   } slrs_stg_s;

   slrs_stg_s st;
   slrs_stg_s next_st;

   always_comb begin
      next_st = st;
      next_st.dly = {st.dly[DELAY_LEN-2:0], bus.init_req};
      if (bus.init_req) begin
         next_st.str = '1;
      end else if (st.str != '0) begin
         next_st.str = st.str - 1'b1;
      end
      next_st.agg = st.dly[DELAY_LEN-1] | (st.str != '0);
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign bus.init_stage   = st.dly[DELAY_LEN-1];
   assign bus.init_stretch = st.str != '0;
   assign bus.init_agg     = st.agg;
endmodule
`default_nettype wire

// ### core/slrs_top.sv
/*
 reset sequencer of a serial link core: debounces the pushbutton reset,
 stages the transceiver initialization request, aggregates the core reset
 and models the link-ready behaviour of duplex and one-way cores.
 assumes all inputs are synchronous to mclk; the user application applies
 resets with the documented minimum widths and ordering.
*/
`timescale 1ns/1ps
`default_nettype none
module slrs_top
   import slrs_pkg::*;
#(
   parameter int unsigned DEBOUNCE_LEN = DEBOUNCE_CYC,
   parameter int unsigned DELAY_LEN    = INIT_DELAY_CYC,
   parameter int unsigned STR_BITS     = STRETCH_BITS,
   parameter int unsigned TX_TIMER     = TX_TIMER_CYC
) (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic pushbutton_reset_in,
   input  wire logic init_req,
   input  wire logic xcvr_reset_busy,
   input  wire logic hot_plug_reset,
   input  wire logic core_reset,
   input  wire logic power_down,
   input  wire logic lane_locked,
   input  wire logic tx_system_reset,
   input  wire logic rx_system_reset,
   input  wire logic rx_lock,
   output var  logic pushbutton_reset,
   output var  logic core_init,
   output var  logic init_stage,
   output var  logic init_stretch,
   output var  logic sys_reset_out,
   output var  logic partner_hot_plug,
   output var  logic user_clk_run,
   output var  logic tx_half_reset,
   output var  logic rx_half_reset,
   output var  logic channel_ready,
   output var  logic tx_channel_ready,
   output var  logic rx_channel_ready,
   output var  logic tx_lane_ready
);
   localparam int unsigned TXC_W = TX_TIMER_BITS;

   typedef struct packed {
      logic              pb;
      logic              init;
      logic              stage;
      logic              stretch;
      logic              sys_rst;
      logic              hot;
      logic              clk_run;
      logic [3:0]        stop_cnt;
      logic              tx_rst;
      logic              rx_rst;
      logic              ch_rdy;
      logic [3:0]        tx_hold;
      logic [3:0]        rx_hold;
      logic              tx_rdy;
      logic              rx_rdy;
      logic [TXC_W-1:0]  tx_cnt;
      logic              tx_lane;
      slrs_state_e       tx_st;
   } slrs_top_s;

   slrs_top_s st;
   slrs_top_s next_st;
   slrs_if    link ();

   assign link.raw_rst  = pushbutton_reset_in;
   assign link.init_req = init_req;

   slrs_debounce #(.DEBOUNCE_LEN(DEBOUNCE_LEN)) u_deb (
      .mclk (mclk),
      .nrst (nrst),
      .bus  (link)
   );

   slrs_stage #(.DELAY_LEN(DELAY_LEN), .STR_BITS(STR_BITS)) u_stg (
      .mclk (mclk),
      .nrst (nrst),
      .bus  (link)
   );

   logic core_rst_any;
   assign core_rst_any = core_reset | power_down | link.init_agg;

   always_comb begin
      next_st = st;
      next_st.pb      = link.clean_rst;
      next_st.init    = link.init_agg;
      next_st.stage   = link.init_stage;
      next_st.stretch = link.init_stretch;
      next_st.sys_rst = link.clean_rst | xcvr_reset_busy | hot_plug_reset;
      next_st.hot     = link.init_agg;

      // transceiver output clock ceases a few cycles after initialization
      if (link.init_agg) begin
         if (st.stop_cnt < 4'(CLK_STOP_CYC)) begin
            next_st.stop_cnt = st.stop_cnt + 4'h1;
         end else begin
            next_st.clk_run = 1'b0;
         end
      end else begin
         next_st.stop_cnt = 4'h0;
         next_st.clk_run  = 1'b1;
      end

      // duplex: reset sampled on mclk, both halves held
      next_st.tx_rst = core_rst_any;
      next_st.rx_rst = core_rst_any;
      next_st.ch_rdy = !core_rst_any && lane_locked;

      // one-way: ready drops after READY_DROP_CYC cycles of reset
      if (tx_system_reset) begin
         if (st.tx_hold < 4'(READY_DROP_CYC)) begin
            next_st.tx_hold = st.tx_hold + 4'h1;
         end
      end else begin
         next_st.tx_hold = 4'h0;
      end
      if (rx_system_reset) begin
         if (st.rx_hold < 4'(READY_DROP_CYC)) begin
            next_st.rx_hold = st.rx_hold + 4'h1;
         end
      end else begin
         next_st.rx_hold = 4'h0;
      end

      if (rx_system_reset && st.rx_hold >= 4'(READY_DROP_CYC - 1)) begin
         next_st.rx_rdy = 1'b0;
      end else if (!rx_system_reset) begin
         next_st.rx_rdy = rx_lock;
      end

      // tx sequencer: train for the timer, then declare ready
      case (st.tx_st)
         SLRS_IDLE: begin
            next_st.tx_st = SLRS_RESET;
         end
         SLRS_RESET: begin
            next_st.tx_cnt = '0;
            if (!tx_system_reset) begin
               next_st.tx_st = SLRS_TRAIN;
            end
         end
         SLRS_TRAIN: begin
            next_st.tx_cnt = st.tx_cnt + 1'b1;
            if (st.tx_cnt == TXC_W'(TX_TIMER - 1)) begin
               next_st.tx_lane = 1'b1;
               next_st.tx_st   = SLRS_READY;
            end
         end
         SLRS_READY: begin
            next_st.tx_rdy = 1'b1;
         end
         default: begin
            next_st.tx_st = SLRS_RESET;
         end
      endcase
      if (tx_system_reset && st.tx_hold >= 4'(READY_DROP_CYC - 1)) begin
         next_st.tx_rdy  = 1'b0;
         next_st.tx_lane = 1'b0;
         next_st.tx_st   = SLRS_RESET;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st         <= '0;
         st.pb      <= 1'b1;
         st.sys_rst <= 1'b1;
         st.clk_run <= 1'b1;
         st.tx_rst  <= 1'b1;
         st.rx_rst  <= 1'b1;
         st.tx_st   <= SLRS_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign pushbutton_reset = st.pb;
   assign core_init        = st.init;
   assign init_stage       = st.stage;
   assign init_stretch     = st.stretch;
   assign sys_reset_out    = st.sys_rst;
   assign partner_hot_plug = st.hot;
   assign user_clk_run     = st.clk_run;
   assign tx_half_reset    = st.tx_rst;
   assign rx_half_reset    = st.rx_rst;
   assign channel_ready    = st.ch_rdy;
   assign tx_channel_ready = st.tx_rdy;
   assign rx_channel_ready = st.rx_rdy;
   assign tx_lane_ready    = st.tx_lane;
endmodule
`default_nettype wire

// ### test/slrs_props.sv
/*
 assertions on the ports of the reset sequencer top.
 assumes simulation values DEBOUNCE_LEN >= 8, TX_TIMER >= 8, STR_BITS >= 4.
*/
`timescale 1ns/1ps
`default_nettype none
module slrs_props
#(
   parameter int DELAY_LEN = 128
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic pushbutton_reset_in,
   input wire logic init_req,
   input wire logic xcvr_reset_busy,
   input wire logic hot_plug_reset,
   input wire logic core_reset,
   input wire logic power_down,
   input wire logic tx_system_reset,
   input wire logic pushbutton_reset,
   input wire logic core_init,
   input wire logic init_stage,
   input wire logic init_stretch,
   input wire logic sys_reset_out,
   input wire logic partner_hot_plug,
   input wire logic user_clk_run,
   input wire logic tx_half_reset,
   input wire logic rx_half_reset,
   input wire logic channel_ready,
   input wire logic tx_channel_ready,
   input wire logic tx_lane_ready
);
   localparam int SD = DELAY_LEN + 1;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_req; $rose(init_req); endsequence
   sequence s_hold; tx_system_reset[*6]; endsequence
   property p_stage; init_req |-> ##SD init_stage; endproperty
   property p_agg; s_req |-> ##3 core_init; endproperty
   property p_str; $fell(init_req) |-> init_stretch[*8]; endproperty
   property p_union;
      (init_stage || init_stretch) |-> ##[0:1] core_init;
   endproperty
   property p_hot; core_init |-> ##[0:1] partner_hot_plug; endproperty
   property p_sys;
      (xcvr_reset_busy || hot_plug_reset) |=> sys_reset_out;
   endproperty
   property p_pbsys; pushbutton_reset |-> sys_reset_out; endproperty
   property p_deb;
      $rose(pushbutton_reset_in) && !pushbutton_reset
         |-> !pushbutton_reset[*8];
   endproperty
   property p_half;
      (core_reset || power_down)
         |=> tx_half_reset && rx_half_reset && !channel_ready;
   endproperty
   property p_clk; $rose(core_init) |-> ##[4:6] !user_clk_run; endproperty
   property p_keep;
      $rose(tx_system_reset) && tx_channel_ready |-> tx_channel_ready[*4];
   endproperty
   property p_drop; s_hold |=> !tx_channel_ready; endproperty
   property p_lane; $fell(tx_system_reset) |-> !tx_lane_ready[*8]; endproperty
   property p_txup; $rose(tx_channel_ready) |-> $past(tx_lane_ready); endproperty
   a_stage: assert property (p_stage) else $error("stage late");
   a_agg: assert property (p_agg) else $error("init not passed");
   a_str: assert property (p_str) else $error("stretch short");
   a_union: assert property (p_union) else $error("union low");
   a_hot: assert property (p_hot) else $error("hot plug low");
   a_sys: assert property (p_sys) else $error("sys reset low");
   a_pbsys: assert property (p_pbsys) else $error("pb not in reset");
   a_deb: assert property (p_deb) else $error("debounce fast");
   a_half: assert property (p_half) else $error("halves run");
   a_clk: assert property (p_clk) else $error("clock runs");
   a_keep: assert property (p_keep) else $error("ready early");
   a_drop: assert property (p_drop) else $error("ready stays");
   a_lane: assert property (p_lane) else $error("lane early");
   a_txup: assert property (p_txup) else $error("tx ready early");
endmodule
bind slrs_top slrs_props #(.DELAY_LEN(DELAY_LEN)) u_props (
   .mclk, .nrst, .pushbutton_reset_in, .init_req, .xcvr_reset_busy,
   .hot_plug_reset, .core_reset, .power_down, .tx_system_reset,
   .pushbutton_reset, .core_init, .init_stage, .init_stretch,
   .sys_reset_out, .partner_hot_plug, .user_clk_run, .tx_half_reset,
   .rx_half_reset, .channel_ready, .tx_channel_ready, .tx_lane_ready);
`default_nettype wire

// ### test/slrs_partner.sv
/*
 user application reset logic facing the sequencer.
 assumes its tasks are called just after a falling mclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module slrs_partner (
   input  wire logic mclk,
   input  wire logic sys_reset_out,
   output var  logic core_reset,
   output var  logic init_req,
   output var  logic tx_system_reset,
   output var  logic rx_system_reset
);
   logic app_rst;
   assign core_reset = app_rst | sys_reset_out;
   initial begin
      app_rst = 1'b0;
      init_req = 1'b0;
      tx_system_reset = 1'b0;
      rx_system_reset = 1'b0;
   end
   task automatic dup_seq();
      app_rst = 1'b1;
      repeat (6) @(negedge mclk);
      init_req = 1'b1;
      repeat (6) @(negedge mclk);
      app_rst = 1'b0;
      @(negedge mclk);
      init_req = 1'b0;
   endtask
   task automatic one_seq(input int gap);
      tx_system_reset = 1'b1;
      rx_system_reset = 1'b1;
      repeat (6) @(negedge mclk);
      rx_system_reset = 1'b0;
      repeat (gap) @(negedge mclk);
      tx_system_reset = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### test/slrs_top_tb.sv
/*
 self-checking bench of the reset sequencer top.
 assumes the partner model drives the core, init and one-way resets.
*/
`timescale 1ns/1ps
`default_nettype none
module slrs_top_tb;
   localparam int DB = 8;
   logic mclk, nrst, pushbutton_reset_in, xcvr_reset_busy, hot_plug_reset;
   logic power_down, lane_locked, rx_lock, core_reset, init_req;
   logic tx_system_reset, rx_system_reset, pushbutton_reset, core_init;
   logic init_stage, init_stretch, sys_reset_out, partner_hot_plug;
   logic user_clk_run, tx_half_reset, rx_half_reset, channel_ready;
   logic tx_channel_ready, rx_channel_ready, tx_lane_ready;
   int   error_cnt, num_checks, seed, n;
   slrs_top #(.DEBOUNCE_LEN(DB), .DELAY_LEN(8), .STR_BITS(4),
              .TX_TIMER(8)) uut (
      .mclk, .nrst, .pushbutton_reset_in, .init_req, .xcvr_reset_busy,
      .hot_plug_reset, .core_reset, .power_down, .lane_locked,
      .tx_system_reset, .rx_system_reset, .rx_lock, .pushbutton_reset,
      .core_init, .init_stage, .init_stretch, .sys_reset_out,
      .partner_hot_plug, .user_clk_run, .tx_half_reset, .rx_half_reset,
      .channel_ready, .tx_channel_ready, .rx_channel_ready, .tx_lane_ready);
   slrs_partner u_app (.mclk, .sys_reset_out, .core_reset, .init_req,
      .tx_system_reset, .rx_system_reset);
   task automatic chk(input string nm, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      #20000;
      error_cnt++;
      results();
   end
   initial begin
      seed = 32'h36CC;
      {nrst, pushbutton_reset_in, xcvr_reset_busy} = 3'h0;
      {hot_plug_reset, power_down, lane_locked, rx_lock} = 4'h0;
      tick(12);
      chk("pb_rst", 1'b1, pushbutton_reset);
      chk("clk_run", 1'b1, user_clk_run);
      nrst = 1'b1;
      tick(2 * DB);
      chk("pb_rel", 1'b0, pushbutton_reset);
      chk("sys_rel", 1'b0, sys_reset_out);
      for (int i = 0; i < 6; i++) begin
         n = 1 + ($unsigned($random(seed)) % (DB - 1));
         pushbutton_reset_in = 1'b1;
         tick(n);
         pushbutton_reset_in = 1'b0;
         tick(3);
         chk("glitch", 1'b0, pushbutton_reset);
      end
      pushbutton_reset_in = 1'b1;
      tick(DB + 5);
      chk("press", 1'b1, sys_reset_out);
      pushbutton_reset_in = 1'b0;
      tick(DB + 5);
      for (int i = 0; i < 2; i++) begin
         {xcvr_reset_busy, hot_plug_reset} = i ? 2'h1 : 2'h2;
         tick(1);
         chk("agg", 1'b1, sys_reset_out);
         {xcvr_reset_busy, hot_plug_reset} = 2'h0;
         tick(1);
         chk("agg_off", 1'b0, sys_reset_out);
      end
      lane_locked = 1'b1;
      tick(3);
      chk("up", 1'b1, channel_ready);
      fork
         u_app.dup_seq();
         begin
            tick(3);
            chk("dn", 1'b0, channel_ready);
            chk("rx_half", 1'b1, rx_half_reset);
         end
      join
      chk("stretch", 1'b1, init_stretch);
      chk("hot", 1'b1, partner_hot_plug);
      tick(3);
      chk("clk_stop", 1'b0, user_clk_run);
      chk("stage", 1'b1, init_stage);
      tick(22);
      chk("init_end", 1'b0, core_init);
      tick(10);
      power_down = 1'b1;
      tick(2);
      chk("pd_half", 1'b1, tx_half_reset);
      chk("pd_clk", 1'b1, user_clk_run);
      power_down = 1'b0;
      rx_lock = 1'b1;
      tick(20);
      for (int i = 0; i < 2; i++) begin
         chk("tx_pre", 1'b1, tx_channel_ready);
         rx_lock = 1'b0;
         fork
            u_app.one_seq(1 + ($unsigned($random(seed)) % 4));
            begin
               tick(3);
               chk("tx_hold", 1'b1, tx_channel_ready);
               tick(3);
               chk("tx_drop", 1'b0, tx_channel_ready);
               tick(1);
               rx_lock = 1'b1;
            end
         join
         n = 0;
         while (tx_channel_ready !== 1'b1 && n < 100) begin
            tick(1);
            n++;
         end
         chk("tx_up", 1'b1, tx_channel_ready);
         chk("rx_first", 1'b1, rx_channel_ready);
         chk("lane", 1'b1, tx_lane_ready);
      end
      results();
   end
endmodule
`default_nettype wire
